// *** pwm_action_qualifier_ab.sv ***
// action qualifier for outputs a and b with an ahb-lite register slave
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
// Function
// - two-bit action: 00 hold, 01 low, 10 high, 11 invert output.
// - toggle drives a low output high and a high output low.
// - bits 11-10 pick the action on compare b match counting down.
// - bits 9-8 pick the action on compare b match counting up.
// - bits 7-6 pick the action on compare a match counting down.
// - bits 5-4 pick the action on compare a match counting up.
// - bits 3-2 pick the action on counter equal to period.
// - bits 1-0 pick the action on counter equal to zero.
// - in up-down mode, direction counts as down at period.
// - in up-down mode, direction counts as up at zero.
// - first register steers only output a, second only output b.
// - bits 15-12 read zero and ignore writes.
module pwm_action_qualifier_ab
  import pwm_aq_pkg::*;
#(
  parameter int CTR_W = CTR_W_DEFAULT
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [BUS_W-1:0] hwdata_i,
  input  wire logic             hready_i,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  output logic [BUS_W-1:0]      hrdata_o,
  input  wire logic [CTR_W-1:0] ctr_i,
  input  wire logic [CTR_W-1:0] period_i,
  input  wire logic [CTR_W-1:0] compare_a_value_i,
  input  wire logic [CTR_W-1:0] compare_b_value_i,
  input  wire logic             count_dir_i,
  input  wire logic             up_down_mode_i,
  output logic                  pwm_out_a_o,
  output logic                  pwm_out_b_o
);
  if (CTR_W < 1 || CTR_W > REG_W) begin : g_check
    $error("CTR_W must lie between 1 and 16");
  end

  typedef struct packed {
    logic [ACTIONS_W-1:0] output_a_event_actions;
    logic [ACTIONS_W-1:0] output_b_event_actions;
    logic [EVT_N-1:0]     prev_match;
    logic                 wr_a;
    logic                 wr_b;
    logic                 hreadyout;
    logic                 hresp;
    logic [BUS_W-1:0]     hrdata;
  } top_state_t;

  top_state_t           state;
  top_state_t           next_state;
  logic [EVT_N-1:0]     match;
  logic [EVT_N-1:0]     hit;
  logic                 dir_eff;
  logic                 access;
  logic [ACTIONS_W-1:0] view_a;
  logic [ACTIONS_W-1:0] view_b;

  always_comb begin
    match[EVT_ZERO]   = (ctr_i == '0);
    match[EVT_PERIOD] = (ctr_i == period_i);
    match[EVT_COMPARE_A_VALUE]   = (ctr_i == compare_a_value_i);
    match[EVT_COMPARE_B_VALUE]   = (ctr_i == compare_b_value_i);
    // a held counter must not retrigger toggles every cycle
    hit = match & ~state.prev_match;
    dir_eff = count_dir_i;
    if (up_down_mode_i && match[EVT_ZERO]) begin
      dir_eff = DIR_UP;
    end else if (up_down_mode_i && match[EVT_PERIOD]) begin
      dir_eff = DIR_DOWN;
    end
  end

  always_comb begin
    next_state = state;
    next_state.prev_match = match;
    next_state.hreadyout  = 1'b1;
    next_state.hresp      = HRESP_OKAY;
    next_state.wr_a       = 1'b0;
    next_state.wr_b       = 1'b0;
    // data phase of a write: reserved bits are never stored
    if (state.wr_a) begin
      next_state.output_a_event_actions = hwdata_i[ACTIONS_W-1:0];
    end
    if (state.wr_b) begin
      next_state.output_b_event_actions = hwdata_i[ACTIONS_W-1:0];
    end
    // read bypass so a read right after a write sees the new value
    view_a = state.wr_a ? hwdata_i[ACTIONS_W-1:0] : state.output_a_event_actions;
    view_b = state.wr_b ? hwdata_i[ACTIONS_W-1:0] : state.output_b_event_actions;
    access = hsel_i && hready_i && htrans_i[1];
    if (access) begin
      next_state.hrdata = '0;
      if (hwrite_i) begin
        if (haddr_i == ADDR_OUT_A) begin
          next_state.wr_a = 1'b1;
        end else if (haddr_i == ADDR_OUT_B) begin
          next_state.wr_b = 1'b1;
        end
      end else begin
        if (haddr_i == ADDR_OUT_A) begin
          next_state.hrdata = {{(BUS_W-ACTIONS_W){1'b0}}, view_a};
        end else if (haddr_i == ADDR_OUT_B) begin
          next_state.hrdata = {{(BUS_W-ACTIONS_W){1'b0}}, view_b};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.output_a_event_actions <= ACTIONS_RESET;
      state.output_b_event_actions <= ACTIONS_RESET;
      state.prev_match             <= '0;
      state.wr_a                   <= 1'b0;
      state.wr_b                   <= 1'b0;
      state.hreadyout              <= 1'b1;
      state.hresp                  <= HRESP_OKAY;
      state.hrdata                 <= '0;
    end else begin
      state <= next_state;
    end
  end

  // each output sees only its own register
  pwm_output_qualifier u_qual_a (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .actions_i       (state.output_a_event_actions),
    .zero_hit_i      (hit[EVT_ZERO]),
    .period_hit_i    (hit[EVT_PERIOD]),
    .compare_a_value_up_hit_i   (hit[EVT_COMPARE_A_VALUE] && dir_eff == DIR_UP),
    .compare_a_value_down_hit_i (hit[EVT_COMPARE_A_VALUE] && dir_eff == DIR_DOWN),
    .compare_b_value_up_hit_i   (hit[EVT_COMPARE_B_VALUE] && dir_eff == DIR_UP),
    .compare_b_value_down_hit_i (hit[EVT_COMPARE_B_VALUE] && dir_eff == DIR_DOWN),
    .out_o           (pwm_out_a_o)
  );

  pwm_output_qualifier u_qual_b (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .actions_i       (state.output_b_event_actions),
    .zero_hit_i      (hit[EVT_ZERO]),
    .period_hit_i    (hit[EVT_PERIOD]),
    .compare_a_value_up_hit_i   (hit[EVT_COMPARE_A_VALUE] && dir_eff == DIR_UP),
    .compare_a_value_down_hit_i (hit[EVT_COMPARE_A_VALUE] && dir_eff == DIR_DOWN),
    .compare_b_value_up_hit_i   (hit[EVT_COMPARE_B_VALUE] && dir_eff == DIR_UP),
    .compare_b_value_down_hit_i (hit[EVT_COMPARE_B_VALUE] && dir_eff == DIR_DOWN),
    .out_o           (pwm_out_b_o)
  );

  assign hreadyout_o = state.hreadyout;
  assign hresp_o     = state.hresp;
  assign hrdata_o    = state.hrdata;
endmodule

// *** pwm_action_qualifier_ab_tb.sv ***
// self-checking bench for the pwm action qualifier
`timescale 1ns/100ps
module pwm_action_qualifier_ab_tb;
  import pwm_aq_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, hwrite = 1'b0, run = 1'b0, ud = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata, hrdata;
  logic        hready, hresp, dir, out_a, out_b, ea, eb, up;
  logic [15:0] ctr, period = 16'h0008, cmp_a = 16'h0003, cmp_b = 16'h0005;
  logic [11:0] act_a = 12'h0, act_b = 12'h0, cfg [4] = '{12'hFFF, 12'h666, 12'h999, 12'h36C};
  logic [3:0]  prev, m;
  int          fails = 0, checks_done = 0, cycles = 0;
  always #25 clk_i = ~clk_i;
  pwm_action_qualifier_ab dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .ctr_i(ctr), .period_i(period),
    .compare_a_value_i(cmp_a), .compare_b_value_i(cmp_b), .count_dir_i(dir),
    .up_down_mode_i(ud), .pwm_out_a_o(out_a), .pwm_out_b_o(out_b));
  pwm_timebase_model tbm (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .ud_i(ud),
    .period_i(period), .ctr_o(ctr), .dir_o(dir));
  assign m = {ctr == cmp_b, ctr == cmp_a, ctr == period, ctr == 16'h0};
  assign up = (ud && ctr == 16'h0) ? 1'b1 : (ud && ctr == period) ? 1'b0 : dir;
  function automatic logic apply(input logic o, input logic [11:0] a, input logic [3:0] h);
    logic [1:0] c;
    c = 2'h0;
    if (h[0] && a[1:0] != 2'h0) c = a[1:0];
    if (h[1] && a[3:2] != 2'h0) c = a[3:2];
    if (h[2] && (up ? a[5:4] : a[7:6]) != 2'h0) c = up ? a[5:4] : a[7:6];
    if (h[3] && (up ? a[9:8] : a[11:10]) != 2'h0) c = up ? a[9:8] : a[11:10];
    return c == 2'h0 ? o : c == 2'h1 ? 1'b0 : c == 2'h2 ? 1'b1 : !o;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, wd, output logic [31:0] r);
    @(posedge clk_i);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic chk_out(input logic got, input logic exp, input logic which);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: out %0d got %b, expected %b", $time, which, got, exp);
    end
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish;
    end
  end
  always @(posedge clk_i) begin
    ea <= rst_i ? OUT_RESET : apply(ea, act_a, m & ~prev);
    eb <= rst_i ? OUT_RESET : apply(eb, act_b, m & ~prev);
    prev <= rst_i ? 4'h0 : m;
  end
  always @(negedge clk_i) begin
    if (!rst_i) begin
      chk_out(out_a, ea, 1'b0);
      chk_out(out_b, eb, 1'b1);
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(ADDR_OUT_A, 32'h0);
    rd_chk(ADDR_OUT_B, 32'h0);
    xfer(1'b1, ADDR_OUT_A, 32'hFFFF_FFFF, rdata);
    xfer(1'b1, ADDR_OUT_B, 32'hFFFF_F000, rdata);
    rd_chk(ADDR_OUT_A, 32'h0000_0FFF);
    rd_chk(ADDR_OUT_B, 32'h0);
    rd_chk(32'h0000_0008, 32'h0);
    // second pass puts compares on zero and period to expose the forced direction
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      ud <= !i[1];
      cmp_a <= i[0] ? 16'h0 : 16'h3;
      cmp_b <= i[0] ? 16'h8 : 16'h5;
      for (int k = 0; k < 4; k++) begin
        xfer(1'b1, ADDR_OUT_A, {20'h0, cfg[k]}, rdata);
        xfer(1'b1, ADDR_OUT_B, {20'h0, cfg[3-k]}, rdata);
        act_a = cfg[k];
        act_b = cfg[3-k];
        rd_chk(ADDR_OUT_B, {20'h0, cfg[3-k]});
        run <= 1'b1;
        repeat (20) @(posedge clk_i);
        run <= 1'b0;
      end
    end
    // reset after the last run has stopped must wipe the programmed actions
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // cleared only once reset is seen, so the model never races an event
    act_a = 12'h0;
    act_b = 12'h0;
    rd_chk(ADDR_OUT_A, 32'h0);
    rd_chk(ADDR_OUT_B, 32'h0);
    tally_and_finish;
  end
endmodule

// *** pwm_aq_pkg.sv ***
// shared constants and types of the pwm action qualifier
package pwm_aq_pkg;
  localparam int          CTR_W_DEFAULT  = 16;
  localparam int          REG_W          = 16;
  localparam int          ACT_W          = 2;
  localparam int          ACTIONS_W      = 12;
  localparam int          BUS_W          = 32;
  localparam logic [31:0] ADDR_OUT_A     = 32'h0000_0000;
  localparam logic [31:0] ADDR_OUT_B     = 32'h0000_0004;
  localparam int          ZERO_LSB       = 0;
  localparam int          PERIOD_LSB     = 2;
  localparam int          COMPARE_A_VALUE_UP_LSB    = 4;
  localparam int          COMPARE_A_VALUE_DOWN_LSB  = 6;
  localparam int          COMPARE_B_VALUE_UP_LSB    = 8;
  localparam int          COMPARE_B_VALUE_DOWN_LSB  = 10;
  localparam logic [ACTIONS_W-1:0] ACTIONS_RESET = 12'h000;
  localparam logic        DIR_UP         = 1'b1;
  localparam logic        DIR_DOWN       = 1'b0;
  localparam logic        HRESP_OKAY     = 1'b0;
  localparam logic        OUT_RESET      = 1'b0;
  localparam int          EVT_ZERO       = 0;
  localparam int          EVT_PERIOD     = 1;
  localparam int          EVT_COMPARE_A_VALUE       = 2;
  localparam int          EVT_COMPARE_B_VALUE       = 3;
  localparam int          EVT_N          = 4;

  typedef enum logic [ACT_W-1:0] {
    ACT_HOLD   = 2'h0,
    ACT_CLEAR  = 2'h1,
    ACT_SET    = 2'h2,
    ACT_TOGGLE = 2'h3
  } action_t;
endpackage

// *** pwm_aq_props.sv ***
// concurrent checks on the action qualifier ports
`timescale 1ns/100ps
module pwm_aq_props
  import pwm_aq_pkg::*;
#(
  parameter int CTR_W = CTR_W_DEFAULT
)(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             hsel_i,
  input wire logic [31:0]      haddr_i,
  input wire logic [1:0]       htrans_i,
  input wire logic             hwrite_i,
  input wire logic             hready_i,
  input wire logic             hreadyout_o,
  input wire logic             hresp_o,
  input wire logic [BUS_W-1:0] hrdata_o,
  input wire logic [CTR_W-1:0] ctr_i,
  input wire logic [CTR_W-1:0] period_i,
  input wire logic [CTR_W-1:0] compare_a_value_i,
  input wire logic [CTR_W-1:0] compare_b_value_i,
  input wire logic             pwm_out_a_o,
  input wire logic             pwm_out_b_o
);
  logic [3:0] match;
  logic [3:0] prev;
  logic       fresh;
  assign match = {ctr_i == compare_b_value_i, ctr_i == compare_a_value_i,
                  ctr_i == period_i, ctr_i == '0};
  // a held match must not act twice, so only rising matches count
  assign fresh = |(match & ~prev);
  always_ff @(posedge clk_i) begin
    prev <= rst_i ? 4'h0 : match;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    hsel_i && hready_i && htrans_i[1];
  endsequence
  sequence s_unmapped_read;
    s_take ##0 (!hwrite_i && haddr_i != ADDR_OUT_A && haddr_i != ADDR_OUT_B);
  endsequence
  // the output flop moves on the event edge, so its change is seen one edge later
  property p_out_a_cause; $changed(pwm_out_a_o) |-> $past(fresh); endproperty
  a_out_a_cause: assert property (p_out_a_cause)
    else $error("out a moved without event");
  property p_out_b_cause; $changed(pwm_out_b_o) |-> $past(fresh); endproperty
  a_out_b_cause: assert property (p_out_b_cause)
    else $error("out b moved without event");
  property p_resv; hrdata_o[31:12] == 20'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved read bits set");
  property p_unmapped; s_unmapped_read |=> hrdata_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_wr_zero; s_take ##0 hwrite_i |=> hrdata_o == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data after write not zero");
  property p_stand; !(hsel_i && hready_i && htrans_i[1]) |=> $stable(hrdata_o); endproperty
  a_stand: assert property (p_stand) else $error("read data moved while idle");
  property p_okay; hresp_o == HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_ready; hreadyout_o; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
endmodule
bind pwm_action_qualifier_ab pwm_aq_props #(.CTR_W(CTR_W)) u_props (
  .clk_i             (clk_i),
  .rst_i             (rst_i),
  .hsel_i            (hsel_i),
  .haddr_i           (haddr_i),
  .htrans_i          (htrans_i),
  .hwrite_i          (hwrite_i),
  .hready_i          (hready_i),
  .hreadyout_o       (hreadyout_o),
  .hresp_o           (hresp_o),
  .hrdata_o          (hrdata_o),
  .ctr_i             (ctr_i),
  .period_i          (period_i),
  .compare_a_value_i (compare_a_value_i),
  .compare_b_value_i (compare_b_value_i),
  .pwm_out_a_o       (pwm_out_a_o),
  .pwm_out_b_o       (pwm_out_b_o)
);

// *** pwm_output_qualifier.sv ***
// one output's action selection and output flop
`timescale 1ns/100ps
module pwm_output_qualifier
  import pwm_aq_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [ACTIONS_W-1:0] actions_i,
  input  wire logic                 zero_hit_i,
  input  wire logic                 period_hit_i,
  input  wire logic                 compare_a_value_up_hit_i,
  input  wire logic                 compare_a_value_down_hit_i,
  input  wire logic                 compare_b_value_up_hit_i,
  input  wire logic                 compare_b_value_down_hit_i,
  output logic                      out_o
);
  typedef struct packed {
    logic out;
  } q_state_t;

  q_state_t state;
  q_state_t next_state;
  action_t  sel;

  function automatic action_t field(input logic [ACTIONS_W-1:0] a, input int lsb);
    field = action_t'(a[lsb +: ACT_W]);
  endfunction

  always_comb begin
    // later events with a non-hold action override earlier ones: compare b has the last word
    sel = ACT_HOLD;
    if (zero_hit_i) begin
      sel = field(actions_i, ZERO_LSB);
    end
    if (period_hit_i && field(actions_i, PERIOD_LSB) != ACT_HOLD) begin
      sel = field(actions_i, PERIOD_LSB);
    end
    if (compare_a_value_up_hit_i && field(actions_i, COMPARE_A_VALUE_UP_LSB) != ACT_HOLD) begin
      sel = field(actions_i, COMPARE_A_VALUE_UP_LSB);
    end
    if (compare_a_value_down_hit_i && field(actions_i, COMPARE_A_VALUE_DOWN_LSB) != ACT_HOLD) begin
      sel = field(actions_i, COMPARE_A_VALUE_DOWN_LSB);
    end
    if (compare_b_value_up_hit_i && field(actions_i, COMPARE_B_VALUE_UP_LSB) != ACT_HOLD) begin
      sel = field(actions_i, COMPARE_B_VALUE_UP_LSB);
    end
    if (compare_b_value_down_hit_i && field(actions_i, COMPARE_B_VALUE_DOWN_LSB) != ACT_HOLD) begin
      sel = field(actions_i, COMPARE_B_VALUE_DOWN_LSB);
    end
    next_state = state;
    case (sel)
      ACT_CLEAR:  next_state.out = 1'b0;
      ACT_SET:    next_state.out = 1'b1;
      ACT_TOGGLE: next_state.out = ~state.out;
      default:    next_state.out = state.out;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.out <= OUT_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign out_o = state.out;
endmodule

// *** pwm_timebase_model.sv ***
// time-base counter stand-in feeding the qualifier
`timescale 1ns/100ps
module pwm_timebase_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        ud_i,
  input  wire logic [15:0] period_i,
  output logic      [15:0] ctr_o,
  output logic             dir_o
);
  logic nd;
  // direction flag lags the turn by a cycle, so the qualifier must force it
  assign nd = !ud_i || (ctr_o != period_i && (ctr_o == 16'h0 || dir_o));
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctr_o <= 16'h0001;
      dir_o <= 1'b1;
    end else if (run_i) begin
      ctr_o <= (!ud_i && ctr_o == period_i) ? 16'h0 : nd ? ctr_o + 16'h1 : ctr_o - 16'h1;
      dir_o <= nd;
    end
  end
endmodule
